// ===== design/cspd_pkg.sv
// Purpose: shared constants and types for channel status and power-down pin logic
// Assumes: two channels (a, b), four low-speed lanes each
// Notes: register offsets are word addresses on the plain register port
package cspd_pkg;
  localparam int CSPD_NCH = 2;
  localparam int CSPD_NLANE = 4;
  localparam int CSPD_AW = 4;
  localparam logic [3:0] CSPD_REG_CTRL_A = 4'h0;
  localparam logic [3:0] CSPD_REG_CTRL_B = 4'h1;
  localparam logic [3:0] CSPD_REG_STAT_A = 4'h2;
  localparam logic [3:0] CSPD_REG_STAT_B = 4'h3;
  localparam logic [3:0] CSPD_REG_ID = 4'h4;
  // control register fields
  localparam int CSPD_CTRL_LOS_EN = 0;
  localparam int CSPD_CTRL_REG_PD = 1;
  localparam int CSPD_CTRL_GPS_MODE = 2;
  localparam int CSPD_CTRL_MUX_LSB = 4;
  localparam int CSPD_CTRL_MUX_W = 2;
  localparam logic [7:0] CSPD_CTRL_RST = 8'h01;
  // status register fields
  localparam int CSPD_STAT_LOS = 0;
  localparam int CSPD_STAT_PD = 1;
  localparam int CSPD_STAT_PARTNER_OK = 2;
  localparam int CSPD_STAT_TX_OK = 3;
  localparam int CSPD_STAT_PD_REL = 4;
  // arbitrary identification value
  localparam logic [7:0] CSPD_ID_VAL = 8'h5A;
  typedef enum logic [1:0] {
    CSPD_MUX_LOS = 2'b00,
    CSPD_MUX_PARTNER_OK = 2'b01,
    CSPD_MUX_TX_OK = 2'b10,
    CSPD_MUX_PD = 2'b11
  } cspd_mux_t;
  typedef enum logic [1:0] {
    CSPD_LOS_RESET = 2'b00,
    CSPD_LOS_SIGNAL = 2'b01,
    CSPD_LOS_LOST = 2'b10
  } cspd_los_state_t;
endpackage

// ===== design/cspd_ch_if.sv
// Purpose: per-channel bundle between top and channel logic
// Assumes: one instance per channel
// Notes: none
`timescale 1ns/1ps
interface cspd_ch_if;
  logic los_en;
  logic reg_pd;
  logic gps_mode;
  logic [1:0] mux_sel;
  logic lvl_low;
  logic lvl_high;
  logic tx_lanes_ok;
  logic pd_low_raw;
  logic partner_ok_raw;
  logic los_state;
  logic pd_active;
  logic partner_ok;
  logic tx_ok;
  logic pd_release;
  logic los_pin_o;
  logic los_pin_oe_n;
  modport top (output los_en, reg_pd, gps_mode, mux_sel, lvl_low, lvl_high, tx_lanes_ok,
    pd_low_raw, partner_ok_raw, input los_state, pd_active, partner_ok, tx_ok, pd_release,
    los_pin_o, los_pin_oe_n);
  modport ch (input los_en, reg_pd, gps_mode, mux_sel, lvl_low, lvl_high, tx_lanes_ok,
    pd_low_raw, partner_ok_raw, output los_state, pd_active, partner_ok, tx_ok, pd_release,
    los_pin_o, los_pin_oe_n);
endinterface

// ===== design/cspd_sync2.sv
// Purpose: two-flop synchroniser for asynchronous pin levels
// Assumes: level inputs only
// Notes: first stage read only by second stage
`timescale 1ns/1ps
module cspd_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic d,
  output logic q
);
  logic meta_q;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// ===== design/cspd_chan.sv
// Purpose: one channel: loss-of-signal, power-down, alignment status, pin mux
// Assumes: analog detector gives low/high threshold flags
// Notes: pins synchronised here
`timescale 1ns/1ps
module cspd_chan (
  input wire logic clk_sys,
  input wire logic nrst,
  cspd_ch_if.ch ch
);
  import cspd_pkg::*;
  logic pd_sync;
  logic ok_sync;
  logic pd_prev_q;
  cspd_los_state_t los_q;
  cspd_los_state_t los_d;
  logic tx_ok_q;
  logic mux_bit;
  logic pd_any;

  cspd_sync2 #(.RST_VAL(1'b1)) u_pd (.clk_sys(clk_sys), .nrst(nrst),
    .d(ch.pd_low_raw), .q(pd_sync));
  cspd_sync2 #(.RST_VAL(1'b0)) u_ok (.clk_sys(clk_sys), .nrst(nrst),
    .d(ch.partner_ok_raw), .q(ok_sync));

  // hysteresis: set at or below low, clear above high, hold between
  always_comb begin
    los_d = los_q;
    case (los_q)
      CSPD_LOS_RESET: los_d = CSPD_LOS_SIGNAL;
      CSPD_LOS_SIGNAL: if (ch.los_en && ch.lvl_low) los_d = CSPD_LOS_LOST;
      CSPD_LOS_LOST: if (ch.lvl_high || !ch.los_en) los_d = CSPD_LOS_SIGNAL;
      default: los_d = CSPD_LOS_RESET;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) los_q <= CSPD_LOS_RESET;
    else los_q <= los_d;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) tx_ok_q <= 1'b0;
    else tx_ok_q <= ch.gps_mode && ch.tx_lanes_ok && pd_sync;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) pd_prev_q <= 1'b1;
    else pd_prev_q <= pd_sync;
  end

  assign ch.los_state = (los_q == CSPD_LOS_LOST);
  assign ch.pd_active = !pd_sync;
  assign ch.partner_ok = ch.gps_mode && ok_sync;
  assign ch.tx_ok = tx_ok_q;
  assign ch.pd_release = pd_sync && !pd_prev_q;
  assign pd_any = !pd_sync || ch.reg_pd;

  always_comb begin
    case (ch.mux_sel)
      CSPD_MUX_LOS: mux_bit = ch.los_state;
      CSPD_MUX_PARTNER_OK: mux_bit = ch.partner_ok;
      CSPD_MUX_TX_OK: mux_bit = tx_ok_q;
      CSPD_MUX_PD: mux_bit = !pd_sync;
      default: mux_bit = ch.los_state;
    endcase
  end

  // reset drives low; either power-down floats the pin
  assign ch.los_pin_o = nrst ? mux_bit : 1'b0;
  assign ch.los_pin_oe_n = nrst && pd_any;
endmodule

// ===== design/cspd_top.sv
// Purpose: channel status and power-down pin logic for channels a and b
// Assumes: 10 MHz clk_sys, synchronous active-low nrst, plain register port
// Notes: serializer datapaths are outside; lane data pass through here
// Function
// - reset forces high-speed transmit differential zero
// - reset forces low-speed outputs differential zero
// - loss indicator 0 signal, 1 lost
// - assert enabled at low, clear above high
// - reset drives loss pin low
// - power-down pin floats loss pin
// - register power-down floats loss pin
// - loss pin multiplexes internal functions
// - drive transmit alignment status to partner
// - low power-down pin powers channel down
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
module cspd_top (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [cspd_pkg::CSPD_AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic hs_tx_data_ch_a,
  input wire logic hs_tx_data_ch_b,
  output logic hs_tx_pos_ch_a,
  output logic hs_tx_neg_ch_a,
  output logic hs_tx_pos_ch_b,
  output logic hs_tx_neg_ch_b,
  input wire logic [cspd_pkg::CSPD_NLANE-1:0] ls_out_data_ch_a,
  input wire logic [cspd_pkg::CSPD_NLANE-1:0] ls_out_data_ch_b,
  output logic [cspd_pkg::CSPD_NLANE-1:0] ls_out_lanes_pos_ch_a,
  output logic [cspd_pkg::CSPD_NLANE-1:0] ls_out_lanes_neg_ch_a,
  output logic [cspd_pkg::CSPD_NLANE-1:0] ls_out_lanes_pos_ch_b,
  output logic [cspd_pkg::CSPD_NLANE-1:0] ls_out_lanes_neg_ch_b,
  input wire logic lvl_low_ch_a,
  input wire logic lvl_high_ch_a,
  input wire logic lvl_low_ch_b,
  input wire logic lvl_high_ch_b,
  input wire logic tx_lanes_ok_ch_a,
  input wire logic tx_lanes_ok_ch_b,
  output logic signal_loss_ch_a,
  output logic signal_loss_oe_n_ch_a,
  output logic signal_loss_ch_b,
  output logic signal_loss_oe_n_ch_b,
  input wire logic partner_rx_aligned_ch_a,
  input wire logic partner_rx_aligned_ch_b,
  output logic local_tx_aligned_ch_a,
  output logic local_tx_aligned_ch_b,
  input wire logic power_down_low_ch_a,
  input wire logic power_down_low_ch_b,
  output logic pd_active_ch_a,
  output logic pd_active_ch_b
);
  import cspd_pkg::*;
  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  logic pd_rel_a_q;
  logic pd_rel_b_q;
  logic [7:0] rdata_d;
  logic [7:0] stat_a;
  logic [7:0] stat_b;

  cspd_ch_if ch_a ();
  cspd_ch_if ch_b ();

  function automatic logic [7:0] cspd_status(input logic los, input logic pd,
      input logic pok, input logic tok, input logic rel);
    cspd_status = 8'h00;
    cspd_status[CSPD_STAT_LOS] = los;
    cspd_status[CSPD_STAT_PD] = pd;
    cspd_status[CSPD_STAT_PARTNER_OK] = pok;
    cspd_status[CSPD_STAT_TX_OK] = tok;
    cspd_status[CSPD_STAT_PD_REL] = rel;
  endfunction

  // control fields to channels
  assign ch_a.los_en = ctrl_a_q[CSPD_CTRL_LOS_EN];
  assign ch_a.reg_pd = ctrl_a_q[CSPD_CTRL_REG_PD];
  assign ch_a.gps_mode = ctrl_a_q[CSPD_CTRL_GPS_MODE];
  assign ch_a.mux_sel = ctrl_a_q[CSPD_CTRL_MUX_LSB +: CSPD_CTRL_MUX_W];
  assign ch_a.lvl_low = lvl_low_ch_a;
  assign ch_a.lvl_high = lvl_high_ch_a;
  assign ch_a.tx_lanes_ok = tx_lanes_ok_ch_a;
  assign ch_a.pd_low_raw = power_down_low_ch_a;
  assign ch_a.partner_ok_raw = partner_rx_aligned_ch_a;
  assign ch_b.los_en = ctrl_b_q[CSPD_CTRL_LOS_EN];
  assign ch_b.reg_pd = ctrl_b_q[CSPD_CTRL_REG_PD];
  assign ch_b.gps_mode = ctrl_b_q[CSPD_CTRL_GPS_MODE];
  assign ch_b.mux_sel = ctrl_b_q[CSPD_CTRL_MUX_LSB +: CSPD_CTRL_MUX_W];
  assign ch_b.lvl_low = lvl_low_ch_b;
  assign ch_b.lvl_high = lvl_high_ch_b;
  assign ch_b.tx_lanes_ok = tx_lanes_ok_ch_b;
  assign ch_b.pd_low_raw = power_down_low_ch_b;
  assign ch_b.partner_ok_raw = partner_rx_aligned_ch_b;

  cspd_chan u_ch_a (.clk_sys(clk_sys), .nrst(nrst), .ch(ch_a.ch));
  cspd_chan u_ch_b (.clk_sys(clk_sys), .nrst(nrst), .ch(ch_b.ch));

  // control registers
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ctrl_a_q <= CSPD_CTRL_RST;
      ctrl_b_q <= CSPD_CTRL_RST;
    end else if (reg_wr) begin
      if (reg_addr == CSPD_REG_CTRL_A) ctrl_a_q <= reg_wdata;
      if (reg_addr == CSPD_REG_CTRL_B) ctrl_b_q <= reg_wdata;
    end
  end

  // sticky power-down release flag, read clears, new release wins
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pd_rel_a_q <= 1'b0;
      pd_rel_b_q <= 1'b0;
    end else begin
      if (ch_a.pd_release) pd_rel_a_q <= 1'b1;
      else if (reg_rd && reg_addr == CSPD_REG_STAT_A) pd_rel_a_q <= 1'b0;
      if (ch_b.pd_release) pd_rel_b_q <= 1'b1;
      else if (reg_rd && reg_addr == CSPD_REG_STAT_B) pd_rel_b_q <= 1'b0;
    end
  end

  assign stat_a = cspd_status(ch_a.los_state, ch_a.pd_active, ch_a.partner_ok,
    ch_a.tx_ok, pd_rel_a_q);
  assign stat_b = cspd_status(ch_b.los_state, ch_b.pd_active, ch_b.partner_ok,
    ch_b.tx_ok, pd_rel_b_q);

  always_comb begin
    case (reg_addr)
      CSPD_REG_CTRL_A: rdata_d = ctrl_a_q;
      CSPD_REG_CTRL_B: rdata_d = ctrl_b_q;
      CSPD_REG_STAT_A: rdata_d = stat_a;
      CSPD_REG_STAT_B: rdata_d = stat_b;
      CSPD_REG_ID: rdata_d = CSPD_ID_VAL;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) reg_rdata <= 8'h00;
    else if (reg_rd) reg_rdata <= rdata_d;
    else reg_rdata <= 8'h00;
  end

  // high-speed transmit, differential zero in reset
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      hs_tx_pos_ch_a <= 1'b0;
      hs_tx_neg_ch_a <= 1'b0;
      hs_tx_pos_ch_b <= 1'b0;
      hs_tx_neg_ch_b <= 1'b0;
    end else begin
      hs_tx_pos_ch_a <= hs_tx_data_ch_a;
      hs_tx_neg_ch_a <= ~hs_tx_data_ch_a;
      hs_tx_pos_ch_b <= hs_tx_data_ch_b;
      hs_tx_neg_ch_b <= ~hs_tx_data_ch_b;
    end
  end

  // low-speed outputs, differential zero in reset
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ls_out_lanes_pos_ch_a <= 4'h0;
      ls_out_lanes_neg_ch_a <= 4'h0;
      ls_out_lanes_pos_ch_b <= 4'h0;
      ls_out_lanes_neg_ch_b <= 4'h0;
    end else begin
      ls_out_lanes_pos_ch_a <= ls_out_data_ch_a;
      ls_out_lanes_neg_ch_a <= ~ls_out_data_ch_a;
      ls_out_lanes_pos_ch_b <= ls_out_data_ch_b;
      ls_out_lanes_neg_ch_b <= ~ls_out_data_ch_b;
    end
  end

  assign signal_loss_ch_a = ch_a.los_pin_o;
  assign signal_loss_oe_n_ch_a = ch_a.los_pin_oe_n;
  assign signal_loss_ch_b = ch_b.los_pin_o;
  assign signal_loss_oe_n_ch_b = ch_b.los_pin_oe_n;
  assign local_tx_aligned_ch_a = ch_a.tx_ok;
  assign local_tx_aligned_ch_b = ch_b.tx_ok;
  assign pd_active_ch_a = ch_a.pd_active;
  assign pd_active_ch_b = ch_b.pd_active;

  // helper: previous reset level
  logic nrst_q;
  always_ff @(posedge clk_sys) nrst_q <= nrst;

  AST_HS_ZERO: assert property (@(posedge clk_sys) !nrst |=>
    (hs_tx_pos_ch_a == hs_tx_neg_ch_a) && (hs_tx_pos_ch_b == hs_tx_neg_ch_b))
    else $error("hs transmit not differential zero after reset");
  AST_LS_ZERO: assert property (@(posedge clk_sys) !nrst |=>
    (ls_out_lanes_pos_ch_a == ls_out_lanes_neg_ch_a) &&
    (ls_out_lanes_pos_ch_b == ls_out_lanes_neg_ch_b))
    else $error("low-speed outputs not differential zero after reset");
  AST_LOS_SET: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ch_a.los_state == 1'b0) && ch_a.los_en && lvl_low_ch_a && nrst_q |=> ch_a.los_state)
    else $error("loss not asserted at low threshold");
  AST_LOS_CLR: assert property (@(posedge clk_sys) disable iff (!nrst)
    ch_a.los_state && lvl_high_ch_a |=> !ch_a.los_state)
    else $error("loss not cleared above high threshold");
  AST_LOS_RST_LOW: assert property (@(posedge clk_sys)
    !nrst |-> !signal_loss_ch_a && !signal_loss_oe_n_ch_a && !signal_loss_ch_b &&
    !signal_loss_oe_n_ch_b)
    else $error("loss pin not driven low in reset");
  AST_PD_FLOAT: assert property (@(posedge clk_sys) disable iff (!nrst)
    $fell(power_down_low_ch_a) ##1 (!power_down_low_ch_a)[*2] |-> signal_loss_oe_n_ch_a)
    else $error("loss pin driven during pin power-down");
  AST_REG_PD_FLOAT: assert property (@(posedge clk_sys) disable iff (!nrst)
    ctrl_b_q[CSPD_CTRL_REG_PD] |-> signal_loss_oe_n_ch_b)
    else $error("loss pin driven during register power-down");
  AST_TX_OK_MODE: assert property (@(posedge clk_sys) disable iff (!nrst)
    !ctrl_a_q[CSPD_CTRL_GPS_MODE] |=> !local_tx_aligned_ch_a)
    else $error("transmit alignment driven outside serializer mode");
  AST_PD_SYNC: assert property (@(posedge clk_sys) disable iff (!nrst)
    $fell(power_down_low_ch_b) |-> !pd_active_ch_b ##1 !pd_active_ch_b)
    else $error("power-down pin used before synchronisation");
  AST_MUX_TX_A: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ch_a.mux_sel == CSPD_MUX_TX_OK) && !signal_loss_oe_n_ch_a |->
    (signal_loss_ch_a == local_tx_aligned_ch_a))
    else $error("loss pin does not show transmit alignment");
  AST_MUX_LOS_B: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ch_b.mux_sel == CSPD_MUX_LOS) && !signal_loss_oe_n_ch_b |->
    (signal_loss_ch_b == ch_b.los_state))
    else $error("loss pin does not show loss state");
  AST_LOS_EN_OFF: assert property (@(posedge clk_sys) disable iff (!nrst)
    !ch_a.los_en |=> !ch_a.los_state)
    else $error("loss held while indication disabled");
  AST_PD_OE_B: assert property (@(posedge clk_sys) disable iff (!nrst)
    pd_active_ch_b |-> signal_loss_oe_n_ch_b)
    else $error("loss pin driven while channel powered down");
  AST_TX_OK_PD: assert property (@(posedge clk_sys) disable iff (!nrst)
    pd_active_ch_b |=> !local_tx_aligned_ch_b)
    else $error("transmit alignment driven while powered down");
  AST_TX_OK_MODE_B: assert property (@(posedge clk_sys) disable iff (!nrst)
    !ctrl_b_q[CSPD_CTRL_GPS_MODE] |=> !local_tx_aligned_ch_b)
    else $error("transmit alignment driven outside serializer mode");
  AST_REG_PD_FLOAT_A: assert property (@(posedge clk_sys) disable iff (!nrst)
    ctrl_a_q[CSPD_CTRL_REG_PD] |-> signal_loss_oe_n_ch_a)
    else $error("loss pin driven during register power-down");
  AST_LOS_SET_B: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ch_b.los_state == 1'b0) && ch_b.los_en && lvl_low_ch_b && nrst_q |=> ch_b.los_state)
    else $error("loss not asserted at low threshold");
  COV_LOS: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(ch_a.los_state));
  COV_REG_PD: cover property (@(posedge clk_sys) disable iff (!nrst)
    $rose(signal_loss_oe_n_ch_b));
  COV_LOS_EN_OFF: cover property (@(posedge clk_sys) disable iff (!nrst)
    ch_a.los_state && !ch_a.los_en);
  COV_PD_REL: cover property (@(posedge clk_sys) disable iff (!nrst) ch_b.pd_release);
  COV_TX_OK: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(local_tx_aligned_ch_a));
endmodule

// ===== verif/cspd_partner.sv
// Purpose: link partner and board control model driving both channels' status pins
// Assumes: pins change just after the rising edge of clk_sys
// Notes: slow mode lags every pin change by one more cycle
`timescale 1ns/1ps
module cspd_partner (
  input wire logic clk_sys,
  input wire logic slow,
  input wire logic [1:0] want_aligned,
  input wire logic [1:0] want_pd,
  output logic [1:0] rx_aligned,
  output logic [1:0] pd_low
);
  logic [1:0] al_q;
  logic [1:0] pd_q;
  initial begin
    al_q = 2'h0;
    pd_q = 2'h0;
    rx_aligned = 2'h0;
    pd_low = 2'h3;
  end
  always @(posedge clk_sys) begin
    al_q <= want_aligned;
    pd_q <= want_pd;
    rx_aligned <= slow ? al_q : want_aligned;
    pd_low <= ~(slow ? pd_q : want_pd);
  end
endmodule

// ===== verif/tb_channel_status_powerdown_pins.sv
// Purpose: self-checking bench for channel status and power-down pin logic
// Assumes: partner model drives alignment and power-down pins
// Notes: register reads are scored through an expectation queue
`timescale 1ns/1ps
module tb_channel_status_powerdown_pins;
  import cspd_pkg::*;
  logic clk_sys, nrst, reg_wr, reg_rd, slow, rd_q;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [1:0] hs_d, hs_p, hs_n, lvl_low, lvl_high, tx_ok, pa, pdl, los, oe_n, txal, pda;
  logic [1:0] want_al, want_pd;
  logic [3:0] lsd_a, lsd_b, lsp_a, lsn_a, lsp_b, lsn_b;
  logic [15:0] expq[$];
  logic [15:0] q_e;
  logic [9:0] dq;
  int errors, num_checks, cyc, c, p, t, s;

  cspd_top dut (
    .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .hs_tx_data_ch_a(hs_d[0]), .hs_tx_data_ch_b(hs_d[1]),
    .hs_tx_pos_ch_a(hs_p[0]), .hs_tx_neg_ch_a(hs_n[0]),
    .hs_tx_pos_ch_b(hs_p[1]), .hs_tx_neg_ch_b(hs_n[1]),
    .ls_out_data_ch_a(lsd_a), .ls_out_data_ch_b(lsd_b),
    .ls_out_lanes_pos_ch_a(lsp_a), .ls_out_lanes_neg_ch_a(lsn_a),
    .ls_out_lanes_pos_ch_b(lsp_b), .ls_out_lanes_neg_ch_b(lsn_b),
    .lvl_low_ch_a(lvl_low[0]), .lvl_high_ch_a(lvl_high[0]),
    .lvl_low_ch_b(lvl_low[1]), .lvl_high_ch_b(lvl_high[1]),
    .tx_lanes_ok_ch_a(tx_ok[0]), .tx_lanes_ok_ch_b(tx_ok[1]),
    .signal_loss_ch_a(los[0]), .signal_loss_oe_n_ch_a(oe_n[0]),
    .signal_loss_ch_b(los[1]), .signal_loss_oe_n_ch_b(oe_n[1]),
    .partner_rx_aligned_ch_a(pa[0]), .partner_rx_aligned_ch_b(pa[1]),
    .local_tx_aligned_ch_a(txal[0]), .local_tx_aligned_ch_b(txal[1]),
    .power_down_low_ch_a(pdl[0]), .power_down_low_ch_b(pdl[1]),
    .pd_active_ch_a(pda[0]), .pd_active_ch_b(pda[1])
  );
  cspd_partner partner (
    .clk_sys(clk_sys), .slow(slow), .want_aligned(want_al), .want_pd(want_pd),
    .rx_aligned(pa), .pd_low(pdl)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] x, input logic [7:0] m);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    expq.push_back({m, x & m});
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  // one-cycle threshold flag, ends where the new state is settled
  task automatic pulse(input int ch, input bit hi);
    @(posedge clk_sys);
    if (hi) lvl_high[ch] <= 1'b1;
    else lvl_low[ch] <= 1'b1;
    @(posedge clk_sys);
    lvl_high[ch] <= 1'b0;
    lvl_low[ch] <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    rd_q <= reg_rd;
    hs_d <= 2'($urandom);
    lsd_a <= 4'($urandom);
    lsd_b <= 4'($urandom);
    cyc++;
    if (cyc == 6000) begin
      errors++;
      end_of_test();
    end
  end
  always @(negedge clk_sys) begin
    if (rd_q === 1'b1) begin
      q_e = expq.pop_front();
      check(reg_rdata & q_e[15:8], q_e[7:0]);
    end
  end

  initial begin
    {nrst, reg_wr, reg_rd, slow, reg_addr, reg_wdata} = '0;
    {lvl_low, lvl_high, tx_ok, want_al, want_pd} = '0;
    errors = 0;
    num_checks = 0;
    void'($urandom(40));
    wt(2);
    check({hs_p, hs_n, 4'h0}, 8'h00);
    check({lsp_a, lsn_a}, 8'h00);
    check({lsp_b, lsn_b}, 8'h00);
    check({los, oe_n, txal, pda}, 8'h00);
    @(posedge clk_sys);
    nrst <= 1'b1;
    $display("test reset done");
    rd(CSPD_REG_CTRL_A, CSPD_CTRL_RST, 8'hFF);
    rd(CSPD_REG_CTRL_B, CSPD_CTRL_RST, 8'hFF);
    wr(CSPD_REG_ID, 8'h00);
    rd(CSPD_REG_ID, CSPD_ID_VAL, 8'hFF);
    rd(4'hF, 8'h00, 8'hFF);
    $display("test registers done");
    for (c = 0; c < 2; c++) begin
      pulse(c, 1'b0);
      check({7'h0, los[c]}, 8'h01);
      rd(CSPD_REG_STAT_A + 4'(c), 8'h01, 8'h01);
      pulse(c, 1'b1);
      check({7'h0, los[c]}, 8'h00);
      pulse(c, 1'b0);
      check({7'h0, los[c]}, 8'h01);
      wr(CSPD_REG_CTRL_A + 4'(c), 8'h00);
      wt(1);
      check({7'h0, los[c]}, 8'h00);
      pulse(c, 1'b0);
      check({7'h0, los[c]}, 8'h00);
      wr(CSPD_REG_CTRL_A + 4'(c), 8'h01);
    end
    $display("test loss done");
    for (int i = 0; i < 8; i++) begin
      s = i % 4;
      c = i / 4;
      p = $urandom % 2;
      t = $urandom % 2;
      wr(CSPD_REG_CTRL_A + 4'(c), 8'h05 | 8'(s << 4));
      @(posedge clk_sys);
      want_al[c] <= p[0];
      tx_ok[c] <= t[0];
      slow <= 1'($urandom);
      wt(6);
      check({7'h0, los[c]}, 8'((s == 1) ? p : (s == 2) ? t : 0));
      check({7'h0, txal[c]}, 8'(t));
      check({6'h0, oe_n}, 8'h00);
      // pairs carry the data one cycle later, complementary outside reset
      dq = {lsd_b, lsd_a, hs_d};
      @(negedge clk_sys);
      check({hs_p, hs_n ^ hs_p, 4'h0}, {dq[1:0], 2'h3, 4'h0});
      check({lsp_a, lsn_a ^ lsp_a}, {dq[5:2], 4'hF});
      check({lsp_b, lsn_b ^ lsp_b}, {dq[9:6], 4'hF});
      rd(CSPD_REG_STAT_A + 4'(c), 8'((p << 2) | (t << 3)), 8'h0C);
    end
    wr(CSPD_REG_CTRL_A, 8'h01);
    @(posedge clk_sys);
    tx_ok <= 2'h3;
    wt(3);
    check({7'h0, txal[0]}, 8'h00);
    $display("test mux and alignment done");
    for (c = 0; c < 2; c++) begin
      wr(CSPD_REG_CTRL_A + 4'(c), 8'h05);
      @(posedge clk_sys);
      slow <= 1'b0;
      wt(3);
      check({7'h0, txal[c]}, 8'h01);
      @(posedge clk_sys);
      want_pd[c] <= 1'b1;
      wt(2);
      check({7'h0, pda[c]}, 8'h00);
      wt(2);
      check({6'h0, pda[c], oe_n[c]}, 8'h03);
      rd(CSPD_REG_STAT_A + 4'(c), 8'h02, 8'h02);
      wt(1);
      check({7'h0, txal[c]}, 8'h00);
      @(posedge clk_sys);
      want_pd[c] <= 1'b0;
      wt(5);
      check({6'h0, pda[c], oe_n[c]}, 8'h00);
      rd(CSPD_REG_STAT_A + 4'(c), 8'h10, 8'h12);
      rd(CSPD_REG_STAT_A + 4'(c), 8'h00, 8'h10);
      wr(CSPD_REG_CTRL_A + 4'(c), 8'h03);
      wt(2);
      check({7'h0, oe_n[c]}, 8'h01);
      wr(CSPD_REG_CTRL_A + 4'(c), 8'h01);
      wt(2);
      check({7'h0, oe_n[c]}, 8'h00);
    end
    $display("test power-down done");
    @(posedge clk_sys);
    nrst <= 1'b0;
    wt(3);
    check({hs_p, hs_n, 4'h0}, 8'h00);
    check({lsp_a, lsn_a} | {lsp_b, lsn_b}, 8'h00);
    check({los, oe_n, 4'h0}, 8'h00);
    $display("test second reset done");
    end_of_test();
  end
endmodule
